// *** pkg/usart_rx_regs.vh ***
// register offsets, field positions, reset values, format codes and timing counts
// for the serial receive section; definitions only
`ifndef USART_RX_REGS_VH
`define USART_RX_REGS_VH

// register offsets on the plain register port
`define RX_STATUS_OFS   6'h2B
`define DATA_PORT_OFS   6'h2F
`define SYNC_PAT_OFS    6'h27
`define RX_CTRL_OFS     6'h29
`define RX_IRQ_EN_OFS   6'h2A

// status register fields
`define ST_FULL_BIT     7
`define ST_OVR_BIT      6
`define ST_PAR_BIT      5
`define ST_FRM_BIT      4
`define ST_FSB_BIT      3
`define ST_MCIP_BIT     2
`define ST_STRIP_BIT    1
`define ST_ON_BIT       0

// control register fields
`define CT_DIV16_BIT    7
`define CT_LEN_HI       6
`define CT_LEN_LO       5
`define CT_FMT_HI       4
`define CT_FMT_LO       3
`define CT_PAR_EN_BIT   2
`define CT_EVEN_BIT     1

// interrupt enable fields
`define IE_FULL_BIT     0
`define IE_ERR_BIT      1

// reset values
`define RX_STATUS_RST   8'h00
`define RX_CTRL_RST     8'h00
`define RX_IRQ_EN_RST   2'h0

// format codes and timing counts
`define FMT_SYNC        2'h0
`define DIV16_LAST      4'hF
`define DIV16_START     4'h7

`endif

// *** verilog/usart_rx.v ***
// receive half of a serial channel: assembly, one-word buffer, status,
// and two interrupt pulse outputs.
// assumes rx_clk and ser_in come from outside clk_sys; the register port
// is on clk_sys and reads answer one cycle later.
//
// Functional notes
// - shift bits into 8-bit register; move to buffer only when buffer empty.
// - each buffer load sets the full flag and raises full interrupt if enabled and not sent to the error channel.
// - data register read returns buffer and clears the full flag.
// - status latched at load, frozen until read; match/in-progress bit may change.
// - two interrupt channels, full and error; flags behave alike either way.
// - one interrupt per character; errors go to error channel if enabled.
// - status at 2B: full,overrun,parity,frame,found/break,match/cip,strip,enable.
// - word ready while full sets overrun; cleared by status read or reset.
// - parity flag reflects the parity check of the buffered character.
// - async frame flag set when non-zero character lacks its stop bit.
// - sync: found bit zero means search; match sets it and starts counting.
// - async break flag stays until a one arrives and status is read.
// - sync match bit set when buffered character equals the sync pattern.
// - async in-progress bit set at start bit, cleared at stop bit.
// - with strip set, sync-pattern characters are discarded silently.
// - software enables after receive clock runs; turnaround sets enable.
// - break while buffer full does not set overrun; break shows after read.
// - word then break while full: both break and overrun set after read.
// - length code 00..11 selects eight, seven, six or five data bits.
// - format code 00 sync; 01,10,11 async with 1, 1.5, 2 stop bits.
// - interrupts are edge events; a disabled channel never recalls an event.
`include "usart_rx_regs.vh"
`default_nettype none

module usart_rx (
   // clock and reset
   input  wire       clk_sys,
   input  wire       reset,
   // serial side
   input  wire       rx_clk,
   input  wire       ser_in,
   // transmitter turnaround event
   input  wire       tx_turnaround,
   // register port
   input  wire [5:0] reg_addr,
   input  wire [7:0] reg_wdata,
   input  wire       reg_wr,
   input  wire       reg_rd,
   output reg  [7:0] reg_rdata,
   // interrupt pulses
   output reg        irq_full,
   output reg        irq_err
);

   localparam ST_IDLE  = 5'b00001;
   localparam ST_DATA  = 5'b00100;
   localparam ST_PAR   = 5'b01000;
   localparam ST_STOP  = 5'b10000;

   // synchronisers: first stage feeds only the second
   reg       rclk_s1_r;
   reg       rclk_s2_r;
   reg       rclk_s3_r;
   reg       si_s1_r;
   reg       si_s2_r;

   // configuration
   reg [7:0] ctrl_r;
   reg [1:0] irq_en_r;
   reg [7:0] pat_r;

   // status and buffer
   reg       bf_r;
   reg       oe_r;
   reg       pe_r;
   reg       fe_r;
   reg       fsb_r;
   reg       match_r;
   reg       ss_r;
   reg       re_r;
   reg [7:0] buf_r;
   reg       brk_pend_r;
   reg       oe_pend_r;
   reg       brk_ack_r;
   reg       mark_r;

   // assembler
   reg [4:0] st_r;
   reg [3:0] phase_r;
   reg [2:0] cnt_r;
   reg [7:0] sh_r;
   reg       pbit_r;
   reg       cip_r;
   reg       done_r;
   reg       found_r;
   reg [7:0] cdata_r;
   reg       cpe_r;
   reg       cfe_r;
   reg       cbrk_r;
   reg       cmatch_r;

   wire [1:0] len_code = ctrl_r[`CT_LEN_HI:`CT_LEN_LO];
   wire       sync_md  = ctrl_r[`CT_FMT_HI:`CT_FMT_LO] == `FMT_SYNC;
   wire       div16    = ctrl_r[`CT_DIV16_BIT];
   wire       par_en   = ctrl_r[`CT_PAR_EN_BIT];
   wire       even     = ctrl_r[`CT_EVEN_BIT];
   wire [2:0] last_bit = 3'h7 - {1'b0, len_code};

   // right-justify the last n received bits
   function [7:0] aln;
      input [7:0] x;
      input [1:0] c;
      begin
         case (c)
            2'h0:    aln = x;
            2'h1:    aln = {1'b0, x[7:1]};
            2'h2:    aln = {2'b0, x[7:2]};
            default: aln = {3'b0, x[7:3]};
         endcase
      end
   endfunction

   wire       rise    = rclk_s2_r & ~rclk_s3_r;
   wire       samp    = div16 ? (rise && phase_r == `DIV16_LAST) : rise;
   wire [7:0] nxt_sh  = {si_s2_r, sh_r[7:1]};
   wire       held    = (st_r == ST_PAR) || (st_r == ST_STOP);
   wire [7:0] data_nw = aln(held ? sh_r : nxt_sh, len_code);
   wire       pbit    = (st_r == ST_STOP) ? pbit_r : si_s2_r;
   wire       par_bad = par_en & ((^data_nw) ^ pbit ^ ~even);
   wire       is_pat  = data_nw == pat_r;

   // sampling of the receive clock and serial line
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         rclk_s1_r <= 1'b0;
         rclk_s2_r <= 1'b0;
         rclk_s3_r <= 1'b0;
         si_s1_r   <= 1'b1;
         si_s2_r   <= 1'b1;
      end else begin
         rclk_s1_r <= rx_clk;
         rclk_s2_r <= rclk_s1_r;
         rclk_s3_r <= rclk_s2_r;
         si_s1_r   <= ser_in;
         si_s2_r   <= si_s1_r;
      end
   end

   // character assembly; results leave as a one-cycle done pulse
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         st_r     <= ST_IDLE;
         phase_r  <= 4'h0;
         cnt_r    <= 3'h0;
         sh_r     <= 8'h00;
         pbit_r   <= 1'b0;
         cip_r    <= 1'b0;
         done_r   <= 1'b0;
         found_r  <= 1'b0;
         cdata_r  <= 8'h00;
         cpe_r    <= 1'b0;
         cfe_r    <= 1'b0;
         cbrk_r   <= 1'b0;
         cmatch_r <= 1'b0;
      end else begin
         done_r  <= 1'b0;
         found_r <= 1'b0;
         if (!re_r) begin
            // disabled receiver holds still
            st_r    <= ST_IDLE;
            phase_r <= 4'h0;
            cip_r   <= 1'b0;
         end else if (sync_md) begin
            cip_r <= 1'b0;
            if (rise) begin
               phase_r <= phase_r + 4'h1;
            end
            if (samp) begin
               case (st_r)
                  ST_DATA: begin
                     sh_r  <= nxt_sh;
                     cnt_r <= cnt_r + 3'h1;
                     if (cnt_r == last_bit) begin
                        cnt_r <= 3'h0;
                        if (par_en) begin
                           st_r <= ST_PAR;
                        end else begin
                           done_r   <= 1'b1;
                           cdata_r  <= data_nw;
                           cpe_r    <= 1'b0;
                           cmatch_r <= is_pat;
                        end
                     end
                  end
                  ST_PAR: begin
                     st_r     <= ST_DATA;
                     done_r   <= 1'b1;
                     cdata_r  <= data_nw;
                     cpe_r    <= par_bad;
                     cmatch_r <= is_pat;
                  end
                  default: begin
                     // search: compare every bit position, counter kept at zero
                     sh_r  <= nxt_sh;
                     cnt_r <= 3'h0;
                     if (!fsb_r && is_pat) begin
                        found_r <= 1'b1;
                        st_r    <= ST_DATA;
                     end
                  end
               endcase
            end
            if (!fsb_r && !found_r && st_r != ST_IDLE) begin
               st_r <= ST_IDLE;                   // back to search
            end
            cfe_r  <= 1'b0;
            cbrk_r <= 1'b0;
         end else begin
            case (st_r)
               ST_IDLE: begin
                  if (si_s2_r) begin
                     phase_r <= 4'h0;
                  end else if (rise) begin
                     phase_r <= phase_r + 4'h1;
                     // div16 wants the low level held to mid bit
                     if (!div16 || phase_r == `DIV16_START) begin
                        st_r    <= ST_DATA;
                        phase_r <= 4'h0;
                        cnt_r   <= 3'h0;
                        cip_r   <= 1'b1;
                     end
                  end
               end
               ST_DATA: begin
                  if (rise) begin
                     phase_r <= phase_r + 4'h1;
                  end
                  if (samp) begin
                     sh_r  <= nxt_sh;
                     cnt_r <= cnt_r + 3'h1;
                     if (cnt_r == last_bit) begin
                        st_r <= par_en ? ST_PAR : ST_STOP;
                     end
                  end
               end
               ST_PAR: begin
                  if (rise) begin
                     phase_r <= phase_r + 4'h1;
                  end
                  if (samp) begin
                     pbit_r <= si_s2_r;
                     st_r   <= ST_STOP;
                  end
               end
               ST_STOP: begin
                  if (rise) begin
                     phase_r <= phase_r + 4'h1;
                  end
                  // only the first stop bit is checked; further stop
                  // time is absorbed by the idle hunt for a start bit
                  if (samp) begin
                     st_r     <= ST_IDLE;
                     phase_r  <= 4'h0;
                     cip_r    <= 1'b0;
                     done_r   <= 1'b1;
                     cdata_r  <= data_nw;
                     cpe_r    <= par_bad;
                     cfe_r    <= !si_s2_r && data_nw != 8'h00;
                     cbrk_r   <= !si_s2_r && data_nw == 8'h00 && !(par_en && pbit_r);
                     cmatch_r <= 1'b0;
                  end
               end
               default: begin
                  st_r <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // register port decode
   wire wr_st   = reg_wr && reg_addr == `RX_STATUS_OFS;
   wire rd_st   = reg_rd && reg_addr == `RX_STATUS_OFS;
   wire rd_dat  = reg_rd && reg_addr == `DATA_PORT_OFS;
   wire strip   = sync_md && ss_r && cmatch_r;
   wire take    = done_r && re_r && !strip;
   wire bf_busy = bf_r && !rd_dat;
   wire ld_brk  = rd_dat && brk_pend_r;
   wire ld_new  = take && !bf_busy && !ld_brk;
   wire c_err   = cpe_r || cfe_r || cbrk_r;
   wire ovr_ev  = take && (bf_busy || ld_brk) && !cbrk_r;

   // buffer, status flags and interrupt pulses
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         bf_r       <= 1'b0;
         oe_r       <= 1'b0;
         pe_r       <= 1'b0;
         fe_r       <= 1'b0;
         fsb_r      <= 1'b0;
         match_r    <= 1'b0;
         ss_r       <= 1'b0;
         re_r       <= 1'b0;
         buf_r      <= 8'h00;
         brk_pend_r <= 1'b0;
         oe_pend_r  <= 1'b0;
         brk_ack_r  <= 1'b0;
         mark_r     <= 1'b0;
         irq_full   <= 1'b0;
         irq_err    <= 1'b0;
      end else begin
         irq_full <= 1'b0;
         irq_err  <= 1'b0;                          // pulses only, nothing kept
         if (wr_st) begin
            ss_r <= reg_wdata[`ST_STRIP_BIT];
            re_r <= reg_wdata[`ST_ON_BIT];
            if (sync_md) begin
               fsb_r <= reg_wdata[`ST_FSB_BIT];     // zero forces search
            end
         end
         if (tx_turnaround) begin
            re_r <= 1'b1;
         end
         if (rd_dat) begin
            bf_r      <= 1'b0;
            oe_pend_r <= 1'b0;
         end
         if (rd_st) begin
            oe_r <= 1'b0;
            if (!sync_md && fsb_r) begin
               brk_ack_r <= 1'b1;
            end
         end
         if (!sync_md && fsb_r && si_s2_r) begin
            mark_r <= 1'b1;
         end
         // break clears after a one bit and a status read
         if (!sync_md && fsb_r && mark_r && brk_ack_r && !ld_brk) begin
            fsb_r     <= 1'b0;
            mark_r    <= 1'b0;
            brk_ack_r <= 1'b0;
         end
         if (found_r && re_r) begin
            fsb_r <= 1'b1;
            if (irq_en_r[`IE_ERR_BIT]) begin
               irq_err <= 1'b1;
            end
         end
         if (ld_brk) begin
            // deferred break delivered once the buffer frees
            bf_r       <= 1'b1;
            buf_r      <= 8'h00;
            pe_r       <= 1'b0;
            fe_r       <= 1'b0;
            fsb_r      <= 1'b1;
            mark_r     <= 1'b0;
            brk_ack_r  <= 1'b0;
            brk_pend_r <= 1'b0;
            oe_pend_r  <= 1'b0;
            if (oe_pend_r) begin
               oe_r <= 1'b1;
            end
            if (irq_en_r[`IE_ERR_BIT]) begin
               irq_err <= 1'b1;
            end else if (irq_en_r[`IE_FULL_BIT]) begin
               irq_full <= 1'b1;
            end
         end
         if (take && cbrk_r && bf_busy) begin
            brk_pend_r <= 1'b1;
         end
         if (ovr_ev) begin
            // buffer and latched flags stay; set wins over a status read
            oe_r      <= 1'b1;
            // lost word is remembered so a later deferred break repeats it
            oe_pend_r <= 1'b1;
            if (irq_en_r[`IE_ERR_BIT]) begin
               irq_err <= 1'b1;
            end else if (irq_en_r[`IE_FULL_BIT]) begin
               irq_full <= 1'b1;
            end
         end
         if (ld_new) begin
            // latch word and its flags, frozen until the data read
            bf_r    <= 1'b1;
            buf_r   <= cdata_r;
            pe_r    <= cpe_r;
            fe_r    <= cfe_r;
            match_r <= cmatch_r;
            if (!sync_md) begin
               fsb_r     <= cbrk_r;
               mark_r    <= 1'b0;
               brk_ack_r <= 1'b0;
            end
            // one pulse per character
            if (c_err && irq_en_r[`IE_ERR_BIT]) begin
               irq_err <= 1'b1;
            end else if (irq_en_r[`IE_FULL_BIT]) begin
               irq_full <= 1'b1;
            end
         end
      end
   end

   // configuration writes; pattern masked to the length in force
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         ctrl_r   <= `RX_CTRL_RST;
         irq_en_r <= `RX_IRQ_EN_RST;
         pat_r    <= 8'h00;
      end else if (reg_wr) begin
         case (reg_addr)
            `RX_CTRL_OFS:   ctrl_r   <= reg_wdata;
            `RX_IRQ_EN_OFS: irq_en_r <= reg_wdata[1:0];
            `SYNC_PAT_OFS:  pat_r    <= aln(8'hFF, len_code) & reg_wdata;
            default:        ctrl_r   <= ctrl_r;
         endcase
      end
   end

   // read data stands in the cycle after the strobe; unmapped reads zero
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `RX_STATUS_OFS: reg_rdata <= {bf_r, oe_r, pe_r, fe_r, fsb_r,
                                          sync_md ? match_r : cip_r,
                                          ss_r, re_r};
            `DATA_PORT_OFS: reg_rdata <= buf_r;
            `SYNC_PAT_OFS:  reg_rdata <= pat_r;
            `RX_CTRL_OFS:   reg_rdata <= ctrl_r;
            `RX_IRQ_EN_OFS: reg_rdata <= {6'h00, irq_en_r};
            default:        reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

endmodule

`default_nettype wire

// *** tb/usart_rx_properties.sv ***
// checker for the serial receive section, bound to its ports
// assumes one clock domain (clk_sys) and the offsets of usart_rx_regs.vh
`include "usart_rx_regs.vh"
`default_nettype none

module usart_rx_properties (
   // clock and reset
   input wire logic       clk_sys,
   input wire logic       reset,
   // serial side and turnaround
   input wire logic       rx_clk,
   input wire logic       ser_in,
   input wire logic       tx_turnaround,
   // register port
   input wire logic [5:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   // interrupt pulses
   input wire logic       irq_full,
   input wire logic       irq_err
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   logic [1:0] ie_r;
   logic       on_r;

   // shadow of the enables, so interrupts can be tied to what software allowed
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         ie_r <= 2'h0;
         on_r <= 1'b0;
      end else begin
         if (reg_wr && reg_addr == `RX_IRQ_EN_OFS)
            ie_r <= reg_wdata[1:0];
         if (reg_wr && reg_addr == `RX_STATUS_OFS)
            on_r <= reg_wdata[`ST_ON_BIT];
         else if (tx_turnaround)
            on_r <= 1'b1;
      end
   end

   sequence st_rd;
      reg_rd && reg_addr == `RX_STATUS_OFS && !tx_turnaround;
   endsequence

   a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data not zero outside a read answer");
   a_unmapped_reads_zero: assert property (reg_rd && reg_addr == 6'h00 |=> reg_rdata == 8'h00)
      else $error("unmapped read returned non-zero");
   a_control_bits_hold: assert property (st_rd ##1 st_rd |=> reg_rdata[1:0] == $past(reg_rdata[1:0]))
      else $error("strip or enable bit changed without a write");
   a_one_channel_only: assert property (!(irq_full && irq_err))
      else $error("both interrupt channels pulsed together");
   a_full_needs_enable: assert property (irq_full |-> $past(ie_r[`IE_FULL_BIT]))
      else $error("full interrupt while its channel is disabled");
   a_err_needs_enable: assert property (irq_err |-> $past(ie_r[`IE_ERR_BIT]))
      else $error("error interrupt while its channel is disabled");
   a_off_stays_quiet: assert property ((irq_full || irq_err) |-> $past(on_r))
      else $error("interrupt while the receiver is disabled");
   a_irq_single_edge: assert property ((irq_full || irq_err) |=> !(irq_full || irq_err) [*8])
      else $error("interrupt pulse not a single edge per character");
endmodule

bind usart_rx usart_rx_properties chk (
   .clk_sys(clk_sys), .reset(reset), .rx_clk(rx_clk), .ser_in(ser_in),
   .tx_turnaround(tx_turnaround), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .irq_full(irq_full), .irq_err(irq_err)
);
`default_nettype wire

// *** tb/usart_rx_far_end.sv ***
// remote serial transmitter driving the receive line and its bit clock
// assumes the bench calls send; the bit clock stands still between calls
`default_nettype none

module usart_rx_far_end (
   // serial outputs
   output var logic rx_clk,
   output var logic ser_in
);
   timeunit 1ns;
   timeprecision 1ps;

   // idle mark, clock parked low
   initial begin
      rx_clk = 1'b0;
      ser_in = 1'b1;
   end

   // bit period 400 ns: slow enough for the two-stage sync on clk_sys
   task automatic bit_out(input logic b);
      ser_in = b;
      #200 rx_clk = 1'b1;
      #200 rx_clk = 1'b0;
   endtask

   // framed: start, n data bits lsb first, parity if par_on, one stop; raw for sync format
   task automatic send(input logic [7:0] d, input int n, input bit par_on, input bit par,
                       input bit framed, input bit stop);
      // start off the clk_sys edges so the pins never move at a sampling edge
      #13;
      if (framed)
         bit_out(1'b0);
      for (int i = 0; i < n; i++)
         bit_out(d[i]);
      if (par_on)
         bit_out(par);
      if (framed)
         bit_out(stop);
      ser_in = 1'b1;
   endtask
endmodule
`default_nettype wire

// *** tb/tb_usart_rx.sv ***
// self-checking bench for the serial receive section
// assumes the far-end model supplies frames; registers reached by the plain port
`include "usart_rx_regs.vh"
`default_nettype none

module tb_usart_rx;
   timeunit 1ns;
   timeprecision 1ps;

   logic       clk_sys;
   logic       reset;
   logic       tx_turnaround;
   logic [5:0] reg_addr;
   logic [7:0] reg_wdata;
   logic       reg_wr;
   logic       reg_rd;
   wire  [7:0] reg_rdata;
   wire        irq_full;
   wire        irq_err;
   wire        rx_clk;
   wire        ser_in;
   int         n_fail;
   int         total_checks;
   int         n_if;
   int         n_ie;
   int         f0;
   int         e0;

   usart_rx dut (
      .clk_sys(clk_sys), .reset(reset), .rx_clk(rx_clk), .ser_in(ser_in),
      .tx_turnaround(tx_turnaround), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .irq_full(irq_full), .irq_err(irq_err)
   );

   usart_rx_far_end far (
      .rx_clk(rx_clk),
      .ser_in(ser_in)
   );

   // 20 MHz system clock
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   // count interrupt pulses per channel
   always @(posedge clk_sys) begin
      if (irq_full === 1'b1)
         n_if++;
      if (irq_err === 1'b1)
         n_ie++;
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk_sys);
      reg_wr    <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rdchk(input logic [5:0] a, input logic [7:0] exp);
      logic [7:0] d;
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk_sys);
      reg_rd   <= 1'b0;
      #1 d = reg_rdata;
      chk(d, exp);
   endtask

   // two reads with no gap between the strobes; each answer stands one cycle
   task automatic rdchk2(input logic [5:0] a, input logic [7:0] exp);
      logic [7:0] d;
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk_sys);
      #1 d = reg_rdata;
      chk(d, exp);
      @(posedge clk_sys);
      reg_rd   <= 1'b0;
      #1 d = reg_rdata;
      chk(d, exp);
   endtask

   // stop sample plus sync and load take well under this many cycles
   task automatic settle();
      repeat (12) @(posedge clk_sys);
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // watchdog well beyond the few thousand cycles the tests need
   initial begin
      repeat (40000) @(posedge clk_sys);
      n_fail++;
      tally_and_finish();
   end

   initial begin
      reset = 1'b1;
      tx_turnaround = 1'b0;
      reg_addr = 6'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      repeat (20) @(posedge clk_sys);
      reset <= 1'b0;
      rdchk(`RX_STATUS_OFS, 8'h00);
      rdchk(6'h00, 8'h00);
      // frame while disabled must leave no trace
      wr(`RX_CTRL_OFS, 8'h08);
      wr(`RX_IRQ_EN_OFS, 8'h01);
      far.send(8'hA5, 8, 0, 0, 1, 1);
      settle();
      rdchk(`RX_STATUS_OFS, 8'h00);
      chk(8'(n_if + n_ie), 8'h00);
      // turnaround sets the enable bit; clock is already parked, so enabling is safe
      @(posedge clk_sys);
      tx_turnaround <= 1'b1;
      @(posedge clk_sys);
      tx_turnaround <= 1'b0;
      rdchk(`RX_STATUS_OFS, 8'h01);
      // mid-frame status read shows the character in progress
      fork
         far.send(8'hA5, 8, 0, 0, 1, 1);
         begin
            repeat (40) @(posedge clk_sys);
            rdchk(`RX_STATUS_OFS, 8'h05);
         end
      join
      settle();
      chk(8'(n_if), 8'h01);
      rdchk(`RX_STATUS_OFS, 8'h81);
      rdchk(`DATA_PORT_OFS, 8'hA5);
      rdchk(`RX_STATUS_OFS, 8'h01);
      // second word while full: overrun, buffer kept
      far.send(8'h3C, 8, 0, 0, 1, 1);
      far.send(8'h5A, 8, 0, 0, 1, 1);
      settle();
      rdchk(`RX_STATUS_OFS, 8'hC1);
      rdchk(`DATA_PORT_OFS, 8'h3C);
      rdchk(`RX_STATUS_OFS, 8'h01);
      // every length code, data right-justified
      for (int c = 0; c < 4; c++) begin
         wr(`RX_CTRL_OFS, {1'b0, 2'(c), 5'h08});
         far.send(8'hFF, 8 - c, 0, 0, 1, 1);
         settle();
         rdchk(`RX_STATUS_OFS, 8'h81);
         rdchk(`DATA_PORT_OFS, 8'hFF >> c);
      end
      // odd parity, error channel on: bad parity goes to the error channel only
      wr(`RX_IRQ_EN_OFS, 8'h03);
      wr(`RX_CTRL_OFS, 8'h0C);
      f0 = n_if;
      e0 = n_ie;
      far.send(8'h01, 8, 1, 1, 1, 1);
      settle();
      chk(8'(n_ie - e0), 8'h01);
      chk(8'(n_if - f0), 8'h00);
      rdchk(`RX_STATUS_OFS, 8'hA1);
      rdchk(`DATA_PORT_OFS, 8'h01);
      far.send(8'h01, 8, 1, 0, 1, 1);
      settle();
      chk(8'(n_if - f0), 8'h01);
      rdchk(`RX_STATUS_OFS, 8'h81);
      rdchk(`DATA_PORT_OFS, 8'h01);
      // missing stop bit: frame fault on non-zero data, break on all zeros
      wr(`RX_CTRL_OFS, 8'h08);
      far.send(8'h55, 8, 0, 0, 1, 0);
      settle();
      rdchk(`RX_STATUS_OFS, 8'h91);
      rdchk(`DATA_PORT_OFS, 8'h55);
      far.send(8'h00, 8, 0, 0, 1, 0);
      settle();
      rdchk(`RX_STATUS_OFS, 8'h89);
      rdchk(`DATA_PORT_OFS, 8'h00);
      rdchk(`RX_STATUS_OFS, 8'h01);
      // break while full: no overrun, break shows after the data read
      far.send(8'h11, 8, 0, 0, 1, 1);
      far.send(8'h00, 8, 0, 0, 1, 0);
      settle();
      rdchk(`RX_STATUS_OFS, 8'h81);
      rdchk(`DATA_PORT_OFS, 8'h11);
      settle();
      rdchk(`RX_STATUS_OFS, 8'h89);
      rdchk(`DATA_PORT_OFS, 8'h00);
      // word lost while full, then a break: both flags after the data read
      far.send(8'h22, 8, 0, 0, 1, 1);
      far.send(8'h33, 8, 0, 0, 1, 1);
      far.send(8'h00, 8, 0, 0, 1, 0);
      settle();
      rdchk(`RX_STATUS_OFS, 8'hC1);
      rdchk(`DATA_PORT_OFS, 8'h22);
      settle();
      rdchk(`RX_STATUS_OFS, 8'hC9);
      rdchk(`DATA_PORT_OFS, 8'h00);
      // sync format, strip on: search finds the pattern, repeats are dropped
      wr(`RX_CTRL_OFS, 8'h00);
      wr(`SYNC_PAT_OFS, 8'h7E);
      wr(`RX_STATUS_OFS, 8'h03);
      far.send(8'h7E, 8, 0, 0, 0, 1);
      far.send(8'h7E, 8, 0, 0, 0, 1);
      far.send(8'h42, 8, 0, 0, 0, 1);
      settle();
      rdchk2(`RX_STATUS_OFS, 8'h8B);
      rdchk(`DATA_PORT_OFS, 8'h42);
      // strip off, found kept: a pattern character is buffered with match set
      wr(`RX_STATUS_OFS, 8'h09);
      far.send(8'h7E, 8, 0, 0, 0, 1);
      settle();
      rdchk(`RX_STATUS_OFS, 8'h8D);
      rdchk(`DATA_PORT_OFS, 8'h7E);
      tally_and_finish();
   end
endmodule
`default_nettype wire
